// ==== nfctf_cfg.svh ====
// Register map, field positions and reset values of the target register
// slice and of its host controller. Included by the package only.
// Function
// - Device keeps its own target identifier register
// - Host sets level register, then writes identifier
// - Size field: 00=4, 01=7, 10=10 bytes
// - Bit 5 enables automatic single device detection
// - Three-bit wake level, all zero means off
// - Bit 3 selects extended field measurement range
// - Level register cleared only by power-on
// - Protocol bits 7,6 show comparators live
// - Protocol bits 4..0 clear after continuous read
// - Rate field: 01=106, 10=212, 11=424 kbps
// - Bits 4,3,2 flag first command type
// - Interrupt status 0x04, 0x08, 0x40 events
// - Type A reads 0xc9, Type B 0xc5
// - Host reads request, answers with matching response
// - Test bits 7,6,5 repurpose keying/modulation pins
// - Decoder/IO test bits cleared at stop
// - Test bit 0 selects fast coder clock
// - Overflow set beyond 127 presented bytes
// - Low seven status bits give FIFO count
// - Twelve-bit byte count split over two registers
// - Bit 0 flags partial byte, bits 3..1 size
// - Length registers clear at reset, disable, end
// - Reading interrupt status clears it
`ifndef NFCTF_CFG_SVH
`define NFCTF_CFG_SVH

// Link register addresses
`define NFCTF_A_IRQ        5'h0c
`define NFCTF_A_ID         5'h17
`define NFCTF_A_DET        5'h18
`define NFCTF_A_PROTO      5'h19
`define NFCTF_A_TPIN       5'h1a
`define NFCTF_A_TMODE      5'h1b
`define NFCTF_A_FIFO       5'h1c
`define NFCTF_A_TXH        5'h1d
`define NFCTF_A_TXL        5'h1e

// Reset values and write masks
`define NFCTF_ZERO8        8'h00
`define NFCTF_DET_MASK     8'hef
`define NFCTF_TMODE_MASK   8'h4f
`define NFCTF_TSTOP_MASK   8'hf1
`define NFCTF_ID_BYTES     10

// Detection level fields
`define NFCTF_DET_SIZE     7:6
`define NFCTF_DET_SDD      5
`define NFCTF_DET_XRANGE   3
`define NFCTF_DET_WAKE     2:0

// Interrupt status bits
`define NFCTF_IRQ_FIELD    2
`define NFCTF_IRQ_SDD      3
`define NFCTF_IRQ_RX       6

// Test pin select and test mode bits
`define NFCTF_TP_SUBC_IN   7
`define NFCTF_TP_SUBC_OUT  6
`define NFCTF_TP_DIRECT    5
`define NFCTF_TM_IO_HI     3
`define NFCTF_TM_IO_LO     2
`define NFCTF_TM_DEC       1
`define NFCTF_TM_FASTCLK   0

// Rate code for 106 kbps and overflow threshold
`define NFCTF_RATE_106     2'b01
`define NFCTF_FIFO_MAX     8'h7f

// Host register word indexes on the system bus
`define NFCTF_H_CMD        3'h0
`define NFCTF_H_STAT       3'h1
`define NFCTF_H_DET        3'h2
`define NFCTF_H_ID0        3'h3
`define NFCTF_H_ID2        3'h5
`define NFCTF_H_NONE       3'h7

// Host command fields
`define NFCTF_C_ADDR       4:0
`define NFCTF_C_DATA       15:8
`define NFCTF_C_WRITE      16
`define NFCTF_C_IDLOAD     17
`define NFCTF_HTRANS_NSEQ  2'b10

`endif

// ==== nfctf_pkg.sv ====
// Types shared by both ends of the target register link.
// Assumes nfctf_cfg.svh in the include path.
`include "nfctf_cfg.svh"
package nfctf_pkg;

  typedef enum logic [1:0] {
    SDD_IDLE = 2'b00,
    SDD_SEND = 2'b01,
    SDD_DONE = 2'b11
  } nfctf_sdd_e;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_XFER = 2'b01,
    H_WAIT = 2'b11,
    H_GAP  = 2'b10
  } nfctf_host_e;

  // Identifier length from the size field; reserved code taken as 4
  function automatic logic [3:0] nfctf_id_len(input logic [1:0] sz);
    case (sz)
      2'b01:   nfctf_id_len = 4'h7;
      2'b10:   nfctf_id_len = 4'ha;
      default: nfctf_id_len = 4'h4;
    endcase
  endfunction : nfctf_id_len

endpackage : nfctf_pkg

// ==== nfctf_link_if.sv ====
// Serial register link between host controller and target register bank.
// Both ends run on the same clock, supplied outside.
`timescale 1ns/1ns
interface nfctf_link_if;
  logic       cs;
  logic       stb;
  logic       wr;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;
  logic       irq;

  modport dev (
    input  cs, stb, wr, addr, wdata,
    output rdata, ack, irq
  );

  modport host (
    output cs, stb, wr, addr, wdata,
    input  rdata, ack, irq
  );
endinterface : nfctf_link_if

// ==== nfctf_dev.sv ====
// Target register bank: identifier, detection level, protocol info,
// test pin muxing, FIFO status and transmit length.
// Assumes one clock; rst is power-on reset; chip_en and comparators async.
`timescale 1ns/1ns
module nfctf_dev
  import nfctf_pkg::*;
(
  // Clock and power-on reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register link
  nfctf_link_if.dev        link,
  // Asynchronous pins and comparators
  input  wire logic        chip_en,
  input  wire logic        wake_comparator_in,
  input  wire logic        avoid_comparator_in,
  input  wire logic        keying_pin,
  // Modulation pin, oe_n low while driven
  input  wire logic        modulation_pin_i,
  output logic             modulation_pin_o,
  output logic             modulation_pin_oe_n,
  // Receive path events
  input  wire logic        field_detect_stb,
  input  wire logic        rx_done_stb,
  input  wire logic        first_cmd_stb,
  input  wire logic [1:0]  first_rate,
  input  wire logic        first_alt_coding,
  input  wire logic        first_passive_req,
  input  wire logic        type_b_flag,
  // Transmit path and test stop
  input  wire logic        tx_eof_stb,
  input  wire logic        test_stop_stb,
  input  wire logic        rx_subcarrier,
  input  wire logic        tx_mod_logic,
  // FIFO
  input  wire logic [7:0]  fifo_presented,
  // Configuration outputs
  output logic [2:0]       wake_level,
  output logic             wake_detect_on,
  output logic             wake_comparator_out,
  output logic             avoid_comparator_out,
  output logic             extended_field_range,
  output logic             sdd_enabled,
  output logic [11:0]      tx_byte_count,
  output logic             tx_partial,
  output logic [2:0]       tx_partial_bits,
  output logic             test_mode,
  output logic             fast_coder_clock,
  output logic             dec_subc_sel,
  output logic             dec_subc_in,
  output logic             tx_mod_ctl,
  // Automatic detection identifier stream
  output logic             id_tx_valid,
  output logic [7:0]       id_tx_data
);

  typedef struct packed {
    logic [4:0]      sy1;
    logic [4:0]      sy2;
    logic [4:0]      sy3;
    logic [4:0]      syn;
    logic [9:0][7:0] id;
    logic [3:0]      id_idx;
    logic [7:0]      det;
    logic [4:0]      proto;
    logic            proto_rd;
    logic            cs_prev;
    logic [7:0]      tpin;
    logic [7:0]      tmode;
    logic [7:0]      txh;
    logic [7:0]      txl;
    logic [7:0]      irqs;
    logic            ovf;
    logic [7:0]      rdata;
    logic            ack;
    nfctf_sdd_e      sdd;
    logic [3:0]      sdd_cnt;
    logic [7:0]      id_out;
    logic            id_vld;
  } nfctf_dev_s;

  nfctf_dev_s s_q;
  nfctf_dev_s s_d;

  // Filtered pin view: {chip_en, wake, avoid, keying, mod_in}
  logic en_f;
  logic wake_f;
  logic avoid_f;
  logic key_f;
  logic modin_f;
  assign {en_f, wake_f, avoid_f, key_f, modin_f} = s_q.syn;

  function automatic logic [7:0] rd_mux(input nfctf_dev_s s,
                                        input logic [4:0] a,
                                        input logic w, input logic v);
    case (a)
      `NFCTF_A_IRQ:   rd_mux = s.irqs;
      `NFCTF_A_ID:    rd_mux = (s.id_idx < `NFCTF_ID_BYTES) ? s.id[s.id_idx]
                                                           : `NFCTF_ZERO8;
      `NFCTF_A_DET:   rd_mux = s.det;
      `NFCTF_A_PROTO: rd_mux = {w, v, 1'b0, s.proto};
      `NFCTF_A_TPIN:  rd_mux = s.tpin;
      `NFCTF_A_TMODE: rd_mux = s.tmode;
      `NFCTF_A_FIFO:  rd_mux = {s.ovf, s.ovf ? 7'h7f : fifo_presented[6:0]};
      `NFCTF_A_TXH:   rd_mux = s.txh;
      `NFCTF_A_TXL:   rd_mux = s.txl;
      default:        rd_mux = `NFCTF_ZERO8;
    endcase
  endfunction : rd_mux

  always_comb begin
    logic [3:0] len;
    logic       wr_en;
    logic       rd_en;
    len   = nfctf_id_len(s_q.det[`NFCTF_DET_SIZE]);
    s_d   = s_q;
    wr_en = link.stb && link.wr;
    rd_en = link.stb && !link.wr;
    // Three-stage filter: change accepted when stages two and three agree
    s_d.sy1 = {chip_en, wake_comparator_in, avoid_comparator_in,
               keying_pin, modulation_pin_i};
    s_d.sy2 = s_q.sy1;
    s_d.sy3 = s_q.sy2;
    s_d.syn = (s_q.sy2 & s_q.sy3) | (s_q.syn & (s_q.sy2 | s_q.sy3));
    s_d.cs_prev = link.cs;
    s_d.ack     = link.stb;
    s_d.id_vld  = 1'b0;
    if (rd_en) begin
      s_d.rdata = rd_mux(s_q, link.addr, wake_f, avoid_f);
    end
    if (!link.cs) begin
      s_d.id_idx = 4'h0;
    end

    // clear after a continuous read ends
    if (s_q.cs_prev && !link.cs && s_q.proto_rd) begin
      s_d.proto    = 5'h00;
      s_d.proto_rd = 1'b0;
    end
    if (rd_en && link.addr == `NFCTF_A_PROTO) begin
      s_d.proto_rd = 1'b1;
    end
    // coding, request, type and rate form the code
    // record first command, set wins over clear
    if (first_cmd_stb && s_d.proto == 5'h00) begin
      s_d.proto = {first_alt_coding, first_passive_req, type_b_flag,
                   first_rate};
    end

    if (rd_en && link.addr == `NFCTF_A_IRQ) begin
      s_d.irqs = `NFCTF_ZERO8;
    end
    if (field_detect_stb) begin
      s_d.irqs[`NFCTF_IRQ_FIELD] = 1'b1;
    end
    if (rx_done_stb) begin
      s_d.irqs[`NFCTF_IRQ_RX] = 1'b1;
    end

    if (tx_eof_stb) begin
      s_d.txh = `NFCTF_ZERO8;
      s_d.txl = `NFCTF_ZERO8;
    end
    if (test_stop_stb) begin
      s_d.tmode = s_q.tmode & `NFCTF_TSTOP_MASK;
    end
    if (fifo_presented > `NFCTF_FIFO_MAX) begin
      s_d.ovf = 1'b1;
    end else if (fifo_presented == `NFCTF_ZERO8) begin
      s_d.ovf = 1'b0;
    end

    if (wr_en) begin
      case (link.addr)
        `NFCTF_A_ID: begin
          // identifier bytes fill in burst order
          if (s_q.id_idx < len) begin
            s_d.id[s_q.id_idx] = link.wdata;
            s_d.id_idx         = s_q.id_idx + 4'h1;
          end
        end
        `NFCTF_A_DET:   s_d.det   = link.wdata & `NFCTF_DET_MASK;
        `NFCTF_A_TPIN:  s_d.tpin  = link.wdata;
        `NFCTF_A_TMODE: s_d.tmode = link.wdata & `NFCTF_TMODE_MASK;
        `NFCTF_A_TXH:   s_d.txh   = link.wdata;
        `NFCTF_A_TXL:   s_d.txl   = link.wdata;
        default:        s_d.det   = s_d.det;
      endcase
    end

    case (s_q.sdd)
      SDD_IDLE: begin
        if (s_q.det[`NFCTF_DET_SDD] && first_cmd_stb && first_passive_req
            && first_rate == `NFCTF_RATE_106) begin
          s_d.sdd     = SDD_SEND;
          s_d.sdd_cnt = 4'h0;
        end
      end
      SDD_SEND: begin
        s_d.id_out  = s_q.id[s_q.sdd_cnt];
        s_d.id_vld  = 1'b1;
        s_d.sdd_cnt = s_q.sdd_cnt + 4'h1;
        if (s_q.sdd_cnt == len - 4'h1) begin
          s_d.sdd = SDD_DONE;
        end
      end
      SDD_DONE: begin
        s_d.irqs[`NFCTF_IRQ_SDD] = 1'b1;
        s_d.sdd                  = SDD_IDLE;
      end
      default: s_d.sdd = SDD_IDLE;
    endcase

    // Chip disabled: all but level and identifier cleared
    if (!en_f) begin
      s_d.proto    = 5'h00;
      s_d.proto_rd = 1'b0;
      s_d.tpin     = `NFCTF_ZERO8;
      s_d.tmode    = `NFCTF_ZERO8;
      s_d.txh      = `NFCTF_ZERO8;
      s_d.txl      = `NFCTF_ZERO8;
      s_d.irqs     = `NFCTF_ZERO8;
      s_d.ovf      = 1'b0;
      s_d.sdd      = SDD_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Link answers
  assign link.rdata = s_q.rdata;
  assign link.ack   = s_q.ack;
  assign link.irq   = |s_q.irqs;

  // wake detection off when level zero
  assign wake_level           = s_q.det[`NFCTF_DET_WAKE];
  assign wake_detect_on       = |s_q.det[`NFCTF_DET_WAKE];
  assign wake_comparator_out  = wake_f & wake_detect_on;
  assign avoid_comparator_out = avoid_f;
  assign extended_field_range = s_q.det[`NFCTF_DET_XRANGE];
  assign sdd_enabled          = s_q.det[`NFCTF_DET_SDD];
  assign tx_byte_count        = {s_q.txh, s_q.txl[7:4]};
  assign tx_partial           = s_q.txl[0];
  assign tx_partial_bits      = s_q.txl[0] ? s_q.txl[3:1] : 3'h0;
  // test mode from decoder or io bits
  assign test_mode            = s_q.tmode[`NFCTF_TM_DEC]
                              | s_q.tmode[`NFCTF_TM_IO_HI]
                              | s_q.tmode[`NFCTF_TM_IO_LO];
  assign fast_coder_clock     = s_q.tmode[`NFCTF_TM_FASTCLK];

  assign dec_subc_sel        = s_q.tpin[`NFCTF_TP_SUBC_IN];
  assign dec_subc_in         = dec_subc_sel & key_f;
  assign tx_mod_ctl          = s_q.tpin[`NFCTF_TP_DIRECT] ? modin_f
                                                          : tx_mod_logic;
  assign modulation_pin_o    = s_q.tpin[`NFCTF_TP_SUBC_OUT] & rx_subcarrier;
  assign modulation_pin_oe_n = !s_q.tpin[`NFCTF_TP_SUBC_OUT]
                             || s_q.tpin[`NFCTF_TP_DIRECT];
  assign id_tx_valid         = s_q.id_vld;
  assign id_tx_data          = s_q.id_out;

endmodule : nfctf_dev

// ==== nfctf_host.sv ====
// Host controller: AHB-Lite registers turned into link register accesses,
// including the level-then-identifier load sequence.
// Assumes one clock shared with the register bank; zero-wait slave.
`timescale 1ns/1ns
module nfctf_host
  import nfctf_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Register link
  nfctf_link_if.host       link
);

  typedef struct packed {
    logic            ap_sel;
    logic [2:0]      ap_idx;
    logic [31:0]     hrdata;
    logic [17:0]     cmd;
    logic [7:0]      det;
    logic [2:0][31:0] idw;
    nfctf_host_e     st;
    logic            id_phase;
    logic [3:0]      cnt;
    logic            busy;
    logic            cs;
    logic            stb;
    logic [4:0]      addr;
    logic [7:0]      wdata;
    logic            wr;
    logic [7:0]      rdata;
  } nfctf_host_s;

  nfctf_host_s s_q;
  nfctf_host_s s_d;

  always_comb begin
    logic [3:0]  len;
    logic [31:0] idb;
    len = nfctf_id_len(s_q.det[`NFCTF_DET_SIZE]);
    idb = s_q.idw[s_q.cnt[3:2]];
    s_d = s_q;
    s_d.stb = 1'b0;
    // Address phase
    if (hready) begin
      s_d.ap_sel = hsel && htrans == `NFCTF_HTRANS_NSEQ;
      // Words past the map must not alias the command word
      s_d.ap_idx = (haddr[31:5] == 27'h0) ? haddr[4:2] : `NFCTF_H_NONE;
      if (hsel && htrans == `NFCTF_HTRANS_NSEQ && !hwrite) begin
        case (s_d.ap_idx)
          `NFCTF_H_CMD:  s_d.hrdata = {14'h0, s_q.cmd};
          `NFCTF_H_STAT: s_d.hrdata = {16'h0, s_q.rdata, 6'h0, link.irq,
                                       s_q.busy};
          `NFCTF_H_DET:  s_d.hrdata = {24'h0, s_q.det};
          3'h3, 3'h4, `NFCTF_H_ID2:
                         s_d.hrdata = s_q.idw[s_d.ap_idx - `NFCTF_H_ID0];
          default:       s_d.hrdata = 32'h0;
        endcase
      end
      s_d.ap_sel = s_d.ap_sel && hwrite;
    end
    // Data phase of a write
    if (s_q.ap_sel) begin
      case (s_q.ap_idx)
        `NFCTF_H_CMD: begin
          if (!s_q.busy) begin
            s_d.cmd      = hwdata[17:0];
            s_d.busy     = 1'b1;
            s_d.st       = H_XFER;
            s_d.cs       = 1'b1;
            s_d.id_phase = 1'b0;
            s_d.cnt      = 4'h0;
          end
        end
        `NFCTF_H_DET:  s_d.det = hwdata[7:0];
        3'h3, 3'h4, `NFCTF_H_ID2:
                       s_d.idw[s_q.ap_idx - `NFCTF_H_ID0] = hwdata;
        default:       s_d.det = s_d.det;
      endcase
    end
    case (s_q.st)
      // Burst opens with an accepted command
      H_IDLE: s_d.cs = s_d.busy;
      H_XFER: begin
        s_d.stb = 1'b1;
        s_d.st  = H_WAIT;
        if (s_q.id_phase) begin
          s_d.addr  = `NFCTF_A_ID;
          s_d.wr    = 1'b1;
          s_d.wdata = idb[8 * s_q.cnt[1:0] +: 8];
        end else if (s_q.cmd[`NFCTF_C_IDLOAD]) begin
          s_d.addr  = `NFCTF_A_DET;
          s_d.wr    = 1'b1;
          s_d.wdata = s_q.det;
        end else begin
          s_d.addr  = s_q.cmd[`NFCTF_C_ADDR];
          s_d.wr    = s_q.cmd[`NFCTF_C_WRITE];
          s_d.wdata = s_q.cmd[`NFCTF_C_DATA];
        end
      end
      H_WAIT: begin
        if (link.ack) begin
          if (!s_q.wr) begin
            s_d.rdata = link.rdata;
          end
          if (s_q.id_phase && s_q.cnt < len - 4'h1) begin
            s_d.cnt = s_q.cnt + 4'h1;
            s_d.st  = H_XFER;
          end else begin
            s_d.cs = 1'b0;
            s_d.st = H_GAP;
          end
        end
      end
      H_GAP: begin
        if (s_q.cmd[`NFCTF_C_IDLOAD] && !s_q.id_phase) begin
          s_d.id_phase = 1'b1;
          s_d.cs       = 1'b1;
          s_d.st       = H_XFER;
        end else begin
          s_d.busy = 1'b0;
          s_d.st   = H_IDLE;
        end
      end
      default: s_d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = s_q.hrdata;
  assign link.cs    = s_q.cs;
  assign link.stb   = s_q.stb;
  assign link.wr    = s_q.wr;
  assign link.addr  = s_q.addr;
  assign link.wdata = s_q.wdata;

endmodule : nfctf_host

// ==== nfctf_link_properties.sv ====
// Link checker: strobe/ack handshake, burst framing, read data hold
// and reserved read bits. Assumes one clock and synchronous rst.
`timescale 1ns/1ns
module nfctf_link_properties (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Link signals
  input wire logic       cs,
  input wire logic       stb,
  input wire logic       wr,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack,
  input wire logic       irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic       rd_q;
  logic [4:0] ra_q;

  // Read strobe and its address, one cycle late
  always_ff @(posedge mclk) begin
    rd_q <= stb && !wr;
    ra_q <= addr;
  end

  ack_after_stb_a: assert property (stb |=> ack)
    else $error("ack missing after strobe");
  ack_cause_a: assert property (ack |-> $past(stb))
    else $error("ack without strobe");
  stb_in_burst_a: assert property (stb |-> cs)
    else $error("strobe outside burst");
  stb_spacing_a: assert property (stb |=> !stb ##1 !stb)
    else $error("strobes too close");
  burst_end_a: assert property ($fell(cs) |-> $past(ack))
    else $error("burst ended without ack");
  rdata_hold_a: assert property ($changed(rdata) |-> ack && rd_q)
    else $error("read data moved outside read");
  proto_rsvd_a: assert property
    (ack && rd_q && ra_q == 5'h19 |-> !rdata[5])
    else $error("protocol reserved bit set");
  test_rsvd_a: assert property
    (ack && rd_q && ra_q == 5'h1b |-> rdata[7] == 1'b0 && rdata[5:4] == 2'b00)
    else $error("test reserved bits set");
  level_rsvd_a: assert property
    (ack && rd_q && ra_q == 5'h18 |-> !rdata[4])
    else $error("level reserved bit set");
endmodule : nfctf_link_properties

// ==== nfc_target_fifo_regs_tb.sv ====
// Testbench: host controller and register bank joined by the link,
// driven over AHB-Lite. Assumes package and design compiled first.
`timescale 1ns/1ns
module nfc_target_fifo_regs_tb
  import nfctf_pkg::*;
;
  logic        mclk, rst, hsel, hwrite, chip_en, keying_pin;
  logic        wake_comparator_in, avoid_comparator_in, modulation_pin_i;
  logic        rx_subcarrier, tx_mod_logic;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  ev, fc;
  logic [7:0]  fifo_presented, rb;
  logic [31:0] haddr, hwdata, rd;
  wire         hready, wake_detect_on, extended_field_range, sdd_enabled;
  wire         tx_partial, test_mode, fast_coder_clock, dec_subc_in;
  wire         tx_mod_ctl, id_tx_valid, modulation_pin_o, modulation_pin_oe_n;
  wire         wake_comparator_out, avoid_comparator_out;
  wire         dec_subc_sel, hresp;
  wire [2:0]   wake_level, tx_partial_bits;
  wire [7:0]   id_tx_data;
  wire [11:0]  tx_byte_count;
  wire [31:0]  hrdata;
  int          fails, samples_checked;
  logic [7:0]  q[$];
  logic [4:0]  ra[7] = '{5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e};
  logic [4:0]  pv[4] = '{5'b01001, 5'b00101, 5'b10010, 5'b00011};
  logic [7:0]  fp[4] = '{8'd5, 8'd127, 8'd128, 8'd0};
  logic [7:0]  fe[4] = '{8'h05, 8'h7f, 8'hff, 8'h00};

  nfctf_link_if link ();
  nfctf_host i_nfctf_host (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
    .link(link));
  nfctf_dev i_nfctf_dev (.mclk, .rst, .link(link), .chip_en,
    .wake_comparator_in, .avoid_comparator_in, .keying_pin,
    .modulation_pin_i, .modulation_pin_o, .modulation_pin_oe_n,
    .field_detect_stb(ev[0]), .rx_done_stb(ev[1]), .first_cmd_stb(ev[2]),
    .first_rate(fc[1:0]), .first_alt_coding(fc[4]),
    .first_passive_req(fc[3]), .type_b_flag(fc[2]), .tx_eof_stb(ev[3]),
    .test_stop_stb(ev[4]), .rx_subcarrier, .tx_mod_logic, .fifo_presented,
    .wake_level, .wake_detect_on, .wake_comparator_out,
    .avoid_comparator_out, .extended_field_range, .sdd_enabled,
    .tx_byte_count, .tx_partial, .tx_partial_bits, .test_mode,
    .fast_coder_clock, .dec_subc_sel, .dec_subc_in, .tx_mod_ctl,
    .id_tx_valid, .id_tx_data);
  nfctf_link_properties i_nfctf_link_properties (.mclk, .rst,
    .cs(link.cs), .stb(link.stb), .wr(link.wr), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .irq(link.irq));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Identifier stream seen during automatic detection
  always @(posedge mclk)
    if (id_tx_valid === 1'b1) q.push_back(id_tx_data);

  task automatic chk(string s, logic [31:0] v, logic [31:0] e);
    samples_checked++;
    if (v !== e) begin
      fails++;
      $display("mismatch %s exp %h seen %h", s, e, v);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic cy(int n);
    repeat (n) @(posedge mclk);
  endtask : cy

  task automatic rdy;
    for (int i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (hready === 1'b1) return;
    end
    fails++;
    tally_and_finish;
  endtask : rdy

  // One AHB single word transfer; read data left in rd
  task automatic ahb(logic w, logic [31:0] a, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    rdy;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask : ahb

  // Link access through the command word, then poll until idle
  task automatic lk(logic [1:0] op, logic [4:0] a, logic [7:0] d);
    ahb(1'b1, 32'h0, {14'h0, op, d, 3'h0, a});
    for (int i = 0; i < 50; i++) begin
      ahb(1'b0, 32'h4, 32'h0);
      if (rd[0] === 1'b0) begin
        rb = rd[15:8];
        return;
      end
    end
    fails++;
    tally_and_finish;
  endtask : lk

  task automatic rw(logic [4:0] a, logic [7:0] d);
    lk(2'b01, a, d);
  endtask : rw

  task automatic rc(logic [4:0] a, logic [7:0] e);
    lk(2'b00, a, 8'h00);
    chk($sformatf("reg_%h", a), {24'h0, rb}, {24'h0, e});
  endtask : rc

  task automatic pl(int i);
    ev[i] <= 1'b1;
    @(posedge mclk);
    ev[i] <= 1'b0;
    @(posedge mclk);
  endtask : pl

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, ev, fc, fifo_presented} = '0;
    {wake_comparator_in, avoid_comparator_in, keying_pin} = 3'b000;
    {modulation_pin_i, rx_subcarrier, tx_mod_logic} = 3'b000;
    {hsize, chip_en, rst, fails, samples_checked} = {3'h2, 2'b11, 64'h0};
    cy(6);
    rst <= 1'b0;
    cy(8);
    foreach (ra[i]) rc(ra[i], 8'h00);
    rw(5'h18, 8'hff);
    ahb(1'b0, 32'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("hresp", hresp, 1'b0);
    rc(5'h18, 8'hef);
    chk("level", {wake_level, wake_detect_on, extended_field_range,
      sdd_enabled}, 32'h3f);
    rw(5'h18, 8'h00);
    chk("wake_off", wake_detect_on, 1'b0);
    rw(5'h18, 8'h01);
    {wake_comparator_in, avoid_comparator_in} <= 2'b11;
    cy(6);
    chk("cmp_out", {wake_comparator_out, avoid_comparator_out},
      32'h3);
    foreach (pv[i]) begin
      fc <= pv[i];
      pl(2);
      rc(5'h19, {3'b110, pv[i]});
      rc(5'h19, 8'hc0);
    end
    wake_comparator_in <= 1'b0;
    cy(6);
    chk("cmp_low", {wake_comparator_out, avoid_comparator_out},
      32'h1);
    rc(5'h19, 8'h40);
    rw(5'h1b, 8'hff);
    rc(5'h1b, 8'h4f);
    chk("test", {test_mode, fast_coder_clock}, 32'h3);
    pl(4);
    rc(5'h1b, 8'h41);
    chk("test_off", test_mode, 1'b0);
    {keying_pin, rx_subcarrier, modulation_pin_i} <= 3'b111;
    rw(5'h1a, 8'h80);
    chk("subc_in", {dec_subc_sel, dec_subc_in}, 32'h3);
    rw(5'h1a, 8'h40);
    chk("mod_out", {modulation_pin_oe_n, modulation_pin_o}, 32'h1);
    rw(5'h1a, 8'h20);
    chk("mod_dir", {modulation_pin_oe_n, tx_mod_ctl}, 32'h3);
    rw(5'h1a, 8'h00);
    chk("mod_norm", tx_mod_ctl, 1'b0);
    rw(5'h1d, 8'hab);
    rw(5'h1e, 8'hc7);
    chk("tx_len", {tx_byte_count, tx_partial, tx_partial_bits},
      32'habcb);
    rw(5'h1e, 8'hc6);
    chk("tx_part", {tx_partial, tx_partial_bits}, 32'h0);
    pl(3);
    rc(5'h1d, 8'h00);
    rc(5'h1e, 8'h00);
    fifo_presented <= 8'd3;
    rc(5'h1c, 8'h03);
    foreach (fp[i]) begin
      fifo_presented <= fp[i];
      rc(5'h1c, fe[i]);
    end
    pl(0);
    pl(1);
    ahb(1'b0, 32'h4, 32'h0);
    chk("irq", rd[1], 1'b1);
    rc(5'h0c, 8'h44);
    rc(5'h0c, 8'h00);
    // Size code 01: seven identifier bytes
    ahb(1'b1, 32'h8, 32'h61);
    ahb(1'b1, 32'hc, 32'h44332211);
    ahb(1'b1, 32'h10, 32'h00776655);
    lk(2'b10, 5'h00, 8'h00);
    rc(5'h18, 8'h61);
    fc <= 5'b01001;
    pl(2);
    cy(12);
    chk("id_n", q.size(), 32'd7);
    foreach (q[i]) chk("id_byte", q[i], 8'h11 * (i + 1));
    rc(5'h0c, 8'h08);
    rw(5'h1d, 8'h12);
    chip_en <= 1'b0;
    cy(8);
    chip_en <= 1'b1;
    cy(8);
    rc(5'h1d, 8'h00);
    rc(5'h18, 8'h61);
    tally_and_finish;
  end
endmodule : nfc_target_fifo_regs_tb
